// ---- include/sadc_pkg.sv ----
// Package with register map, field layout and timing constants of the converter control block
package sadc_pkg;

  // Register addresses in the data space
  localparam logic [7:0] SADC_RESULT_ADDR = 8'hd0;
  localparam logic [7:0] SADC_CTRL_ADDR = 8'hd1;

  // Control register field positions
  localparam int SADC_IRQ_EN_BIT = 7;
  localparam int SADC_DONE_BIT = 6;
  localparam int SADC_GO_BIT = 5;
  localparam int SADC_PWR_BIT = 4;

  // Control register value after reset
  localparam logic [7:0] SADC_CTRL_RESET = 8'h40;

  // Interrupt vector number of the end-of-conversion request
  localparam logic [2:0] SADC_IRQ_VECTOR = 3'h4;

  // Conversion clock divider and result width
  localparam int SADC_CLK_DIV = 12;
  localparam int SADC_RES_BITS = 8;

  // Typical conversion time at the reference oscillator rate
  localparam int SADC_CONV_TIME_NS = 70000;
  localparam int SADC_REF_OSC_KHZ = 8000;
  // Conversion clock ticks per conversion: 70 us * 8 MHz / 12, rounded down
  localparam int SADC_CONV_TICKS = (SADC_CONV_TIME_NS * SADC_REF_OSC_KHZ) /
                                   (1000000 * SADC_CLK_DIV);

  // Sequencer states
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_SETTLE = 2'b01,
    SADC_STEP = 2'b10
  } sadc_state_t;

  // Register read or write request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sadc_bus_t;

endpackage : sadc_pkg

// ---- hw/sadc_clkdiv.sv ----
// Divider producing a one-cycle conversion clock tick every DIV oscillator cycles
`timescale 1ns/1ns
module sadc_clkdiv import sadc_pkg::*; #(
  parameter int DIV = SADC_CLK_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Restart the division phase
  input wire logic restart_in,
  // Tick output
  output logic tick_out
);

  // Counter wide enough for any divider setting
  localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CNT_W-1:0] count;
  wire last_w = (count == CNT_W'(DIV - 1));

  // Count oscillator cycles, restart keeps a full period before the first tick
  always_ff @(posedge clk_in) begin
    if (rst_in || restart_in || last_w) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

  assign tick_out = last_w && !restart_in;

endmodule : sadc_clkdiv

// ---- hw/sadc_sar.sv ----
// Successive approximation register deciding one result bit per step, MSB first
`timescale 1ns/1ns
module sadc_sar import sadc_pkg::*; #(
  parameter int BITS = SADC_RES_BITS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic load_in,
  input wire logic step_in,
  // Comparator: analog input at or above trial value
  input wire logic cmp_above_in,
  // Trial value to the DAC and running code
  output logic [BITS-1:0] trial_out,
  output logic [BITS-1:0] code_out,
  output logic last_out
);

  logic [BITS-1:0] code;
  logic [BITS-1:0] probe;

  // Probe walks from the top bit down
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      code <= '0;
      probe <= '0;
    end else if (load_in) begin
      code <= '0;
      probe <= {1'b1, {(BITS-1){1'b0}}};
    end else if (step_in) begin
      code <= cmp_above_in ? (code | probe) : code;
      probe <= probe >> 1;
    end
  end

  assign trial_out = code | probe;
  assign code_out = code;
  assign last_out = probe[0];

endmodule : sadc_sar

// ---- hw/sadc_ctrl.sv ----
// Converter control, status and result registers with conversion sequencer
//
// Functional notes
// - Writing one to the go bit starts a conversion if the power bit is already one.
// - Writing the go bit clears the done flag at the same time.
// - Finishing a conversion sets the done flag, result now valid.
// - Go bit written during a conversion aborts it and starts afresh.
// - Go bit is write only and always reads zero.
// - Done flag with interrupt enabled raises request on vector four.
// - Top control bit enables the end-of-conversion interrupt.
// - Power bit one enables converter, zero puts it in idle.
// - Reset aborts conversion and loads control with 40h.
// - Conversion clock is the oscillator divided by twelve.
// - A conversion takes about 70 us at 8 MHz.
// - Conversions are single shot, each needs a new go write.
// - Done flag is read only and serves as interrupt pending.
// - Eight-bit result by successive approximation.
// - Converter and its interrupt keep running in wait mode.
// - Read-only result register at 0D0h shows the conversion result.
`timescale 1ns/1ns
module sadc_ctrl import sadc_pkg::*; #(
  parameter int BITS = SADC_RES_BITS,
  parameter int CONV_TICKS = SADC_CONV_TICKS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data space access from the core
  input wire sadc_bus_t bus_in,
  output logic [7:0] rdata_out,
  // Low power mode of the core, no effect on the converter
  input wire logic wait_mode_in,
  // Analog front end
  input wire logic cmp_above_in,
  output logic [BITS-1:0] dac_out,
  output logic analog_power_out,
  // Interrupt request
  output logic irq_out,
  output logic [2:0] irq_vector_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic irq_enable;
  logic power_on;
  logic done;
  logic [BITS-1:0] result;
  sadc_state_t state;
  logic [7:0] settle_cnt;

  wire ctrl_wr_w = bus_in.wr && (bus_in.addr == SADC_CTRL_ADDR);
  wire go_w = ctrl_wr_w && bus_in.wdata[SADC_GO_BIT];
  wire tick_w;
  wire sar_last_w;
  wire [BITS-1:0] sar_code_w;
  wire busy_w = (state != SADC_IDLE);
  wire step_w = (state == SADC_STEP) && tick_w;
  wire finish_w = step_w && sar_last_w;
  // Final code includes the decision on the last bit
  wire [BITS-1:0] final_w = cmp_above_in ? (sar_code_w | BITS'(1)) : sar_code_w;
  // Settling ticks before the bit decisions fill out the typical conversion time
  localparam int SETTLE_TICKS = (CONV_TICKS > BITS) ? (CONV_TICKS - BITS) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock and approximation register

  sadc_clkdiv #(.DIV(SADC_CLK_DIV)) u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .restart_in(go_w),
    .tick_out(tick_w)
  );

  sadc_sar #(.BITS(BITS)) u_sar (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(go_w),
    .step_in(step_w),
    .cmp_above_in(cmp_above_in),
    .trial_out(dac_out),
    .code_out(sar_code_w),
    .last_out(sar_last_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register bits

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_enable <= SADC_CTRL_RESET[SADC_IRQ_EN_BIT];
      power_on <= SADC_CTRL_RESET[SADC_PWR_BIT];
    end else if (ctrl_wr_w) begin
      irq_enable <= bus_in.wdata[SADC_IRQ_EN_BIT];
      power_on <= bus_in.wdata[SADC_PWR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: settle, then one bit per conversion tick

  sadc_state_t next_state;
  logic [7:0] next_settle_cnt;

  always_comb begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    unique case (state)
      SADC_IDLE: ;
      SADC_SETTLE: begin
        if (tick_w) begin
          if (settle_cnt == 8'h1) begin
            next_state = SADC_STEP;
          end
          next_settle_cnt = settle_cnt - 8'h1;
        end
      end
      SADC_STEP: begin
        if (finish_w) begin
          next_state = SADC_IDLE;
        end
      end
      default: next_state = SADC_IDLE;
    endcase
    if (go_w) begin
      next_state = SADC_SETTLE;
      next_settle_cnt = 8'(SETTLE_TICKS);
    end
    if (!power_on) begin
      next_state = SADC_IDLE;
    end
  end

  // Sequencer registers; wait mode does not gate them
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= SADC_IDLE;
      settle_cnt <= 8'h0;
    end else begin
      state <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done flag and result; a start in the finishing cycle wins, as it aborts the old one

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done <= SADC_CTRL_RESET[SADC_DONE_BIT];
      result <= '0;
    end else if (finish_w && !go_w) begin
      done <= 1'b1;
      result <= final_w;
    end else if (go_w) begin
      done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and outputs

  wire [7:0] ctrl_rd_w = {irq_enable, done, 1'b0, power_on, 4'h0};
  wire [7:0] res_rd_w = 8'(result);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h0;
    end else if (bus_in.rd) begin
      rdata_out <= (bus_in.addr == SADC_CTRL_ADDR) ? ctrl_rd_w :
                   (bus_in.addr == SADC_RESULT_ADDR) ? res_rd_w : 8'h0;
    end
  end

  assign irq_out = done && irq_enable;
  assign irq_vector_out = SADC_IRQ_VECTOR;
  assign analog_power_out = power_on;

  ////////////////////////////////////////////////////////////////////////////
  // Checker helpers: cycles since the last tick and since the last start

  localparam int CONV_CYCLES = (SETTLE_TICKS + BITS) * SADC_CLK_DIV;
  logic [7:0] since_tick;
  logic [15:0] conv_cycles;

  // Counts the cycles since the last conversion clock tick
  always_ff @(posedge clk_in) begin
    if (rst_in || go_w || tick_w) begin
      since_tick <= 8'h0;
    end else begin
      since_tick <= since_tick + 8'h1;
    end
  end

  // Counts the cycles of the running conversion
  always_ff @(posedge clk_in) begin
    if (rst_in || go_w) begin
      conv_cycles <= 16'h0;
    end else if (busy_w) begin
      conv_cycles <= conv_cycles + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Steps of a start and of a completion
  sequence s_go_powered;
    go_w && power_on;
  endsequence

  sequence s_settle_loaded;
    (state == SADC_SETTLE) && (settle_cnt == 8'(SETTLE_TICKS));
  endsequence

  sequence s_finish_enabled;
    finish_w && irq_enable && !ctrl_wr_w;
  endsequence

  property p_go_clears_done;
    @(posedge clk_in) disable iff (rst_in)
      go_w |=> !done && (busy_w == $past(power_on));
  endproperty
  a_go_clears_done: assert property (p_go_clears_done) else $error("go left done set");

  property p_finish_sets_done;
    @(posedge clk_in) disable iff (rst_in)
      finish_w && !go_w |=> done && (result == $past(final_w));
  endproperty
  a_finish_sets_done: assert property (p_finish_sets_done) else $error("done not set");

  property p_irq_gate;
    @(posedge clk_in) disable iff (rst_in)
      s_finish_enabled |=> irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

  property p_go_reads_zero;
    @(posedge clk_in) disable iff (rst_in)
      $past(bus_in.rd) && $past(bus_in.addr) == SADC_CTRL_ADDR |-> !rdata_out[SADC_GO_BIT];
  endproperty
  a_go_reads_zero: assert property (p_go_reads_zero) else $error("go bit read as one");

  property p_reset_value;
    @(posedge clk_in) rst_in |=> !irq_enable && done && !power_on && !busy_w;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset state");

  property p_power_off_idle;
    @(posedge clk_in) disable iff (rst_in)
      !power_on |=> !busy_w;
  endproperty
  a_power_off_idle: assert property (p_power_off_idle) else $error("busy while off");

  property p_single_shot;
    @(posedge clk_in) disable iff (rst_in)
      !busy_w && !go_w |=> !busy_w;
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("spurious start");

  property p_done_read_only;
    @(posedge clk_in) disable iff (rst_in)
      ctrl_wr_w && !go_w && !finish_w |=> done == $past(done);
  endproperty
  a_done_read_only: assert property (p_done_read_only) else $error("done written");

  property p_enable_follows_write;
    @(posedge clk_in) disable iff (rst_in)
      ctrl_wr_w |=> irq_enable == $past(bus_in.wdata[SADC_IRQ_EN_BIT]);
  endproperty
  a_enable_follows_write: assert property (p_enable_follows_write) else $error("enable");

  property p_tick_spacing;
    @(posedge clk_in) disable iff (rst_in)
      tick_w |=> !tick_w [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too early");

  property p_go_restarts;
    @(posedge clk_in) disable iff (rst_in)
      s_go_powered |=> s_settle_loaded;
  endproperty
  a_go_restarts: assert property (p_go_restarts) else $error("no reload");

  property p_msb_first;
    @(posedge clk_in) disable iff (rst_in)
      go_w |=> dac_out == {1'b1, {(BITS-1){1'b0}}};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("trial not top bit");

  property p_result_held;
    @(posedge clk_in) disable iff (rst_in)
      !rst_in && !finish_w |=> $stable(result);
  endproperty
  a_result_held: assert property (p_result_held) else $error("result moved");

  property p_wait_runs;
    @(posedge clk_in) disable iff (rst_in)
      wait_mode_in && finish_w |=> done;
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("no completion in wait");

  property p_power_pin;
    @(posedge clk_in) disable iff (rst_in)
      ctrl_wr_w |=> analog_power_out == $past(bus_in.wdata[SADC_PWR_BIT]);
  endproperty
  a_power_pin: assert property (p_power_pin) else $error("power pin");

  property p_rdata_result;
    @(posedge clk_in) disable iff (rst_in)
      bus_in.rd && (bus_in.addr == SADC_RESULT_ADDR) |=> rdata_out == $past(res_rd_w);
  endproperty
  a_rdata_result: assert property (p_rdata_result) else $error("result read");

  property p_conv_length;
    @(posedge clk_in) disable iff (rst_in)
      finish_w |-> conv_cycles == 16'(CONV_CYCLES - 1);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length");

  property p_tick_period;
    @(posedge clk_in) disable iff (rst_in)
      tick_w |-> since_tick == 8'(SADC_CLK_DIV - 1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period");

endmodule : sadc_ctrl

// ---- verif/sadc_analog_model.sv ----
// Behavioural analog source and comparator for the one selected input
`timescale 1ns/1ns
module sadc_analog_model (
  // Input level in result codes
  input wire logic [7:0] level_in,
  // Trial code from the converter
  input wire logic [7:0] dac_in,
  // Comparator result
  output logic cmp_above_out
);
  // One input only, so never more than one analog line at a time
  assign cmp_above_out = (level_in >= dac_in);
endmodule : sadc_analog_model

// ---- verif/sadc_ctrl_tb.sv ----
// Self-checking testbench of the converter control block
`timescale 1ns/1ns
module sadc_ctrl_tb import sadc_pkg::*; ;
  localparam int TICKS = 10;
  localparam int CONV = TICKS * SADC_CLK_DIV;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  sadc_bus_t bus_in = '0;
  logic wait_mode_in = 1'b0;
  logic [7:0] level = 8'h00;
  logic [7:0] rdata_out;
  logic [7:0] dac_out;
  logic [7:0] d;
  logic cmp_above;
  logic analog_power_out;
  logic irq_out;
  logic [2:0] irq_vector_out;
  int error_cnt = 0;
  int num_checks = 0;
  int n;

  ////////////////////////////////////////////////////////////////////////////
  // Design and analog source
  sadc_ctrl #(.BITS(8), .CONV_TICKS(TICKS)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .wait_mode_in(wait_mode_in), .cmp_above_in(cmp_above), .dac_out(dac_out),
    .analog_power_out(analog_power_out), .irq_out(irq_out),
    .irq_vector_out(irq_vector_out));
  sadc_analog_model src (.level_in(level), .dac_in(dac_out), .cmp_above_out(cmp_above));

  // Clock of 40 ns period
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Expected control register image from its fields, go bit always zero
  function automatic logic [7:0] ctrl_val(input logic en, input logic dn, input logic pw);
    ctrl_val = 8'h00;
    ctrl_val[SADC_IRQ_EN_BIT] = en;
    ctrl_val[SADC_DONE_BIT] = dn;
    ctrl_val[SADC_PWR_BIT] = pw;
  endfunction : ctrl_val

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask : wr

  // One-cycle register read, data one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1 v = rdata_out;
  endtask : rd

  // Full conversion of one level, timed by the interrupt request
  task automatic convert(input logic [7:0] lvl);
    @(posedge clk_in);
    level <= lvl;
    wait_mode_in <= 1'($urandom);
    wr(SADC_CTRL_ADDR, 8'h10);
    wr(SADC_CTRL_ADDR, 8'hb0);
    n = 0;
    #1;
    while (irq_out !== 1'b1 && n < 3 * CONV) begin
      @(posedge clk_in);
      #1 n++;
    end
    check("conversion time", 8'h01, 8'(n >= CONV - 12 && n <= CONV + 12));
    if (n >= 3 * CONV) close_out();
    check("irq vector", 8'h04, {5'h00, irq_vector_out});
    rd(SADC_RESULT_ADDR, d);
    check("result", lvl, d);
    rd(SADC_CTRL_ADDR, d);
    check("control after done", ctrl_val(1'b1, 1'b1, 1'b1), d);
  endtask : convert

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    void'($urandom(13));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(SADC_CTRL_ADDR, d);
    check("control at reset", SADC_CTRL_RESET, d);
    rd(SADC_RESULT_ADDR, d);
    check("result at reset", 8'h00, d);
    rd(8'hd2, d);
    check("unmapped read", 8'h00, d);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      convert(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom));
    end
    $display("test conversions done");
    @(posedge clk_in);
    level <= ~level;
    repeat (CONV + 24) @(posedge clk_in);
    rd(SADC_RESULT_ADDR, d);
    check("no second shot", ~level, d);
    wr(SADC_RESULT_ADDR, 8'h5a);
    rd(SADC_RESULT_ADDR, d);
    check("result read only", ~level, d);
    wr(SADC_CTRL_ADDR, 8'h50);
    rd(SADC_CTRL_ADDR, d);
    check("masked control", 8'h50, d);
    check("masked irq", 8'h00, {7'h00, irq_out});
    wr(SADC_CTRL_ADDR, 8'h80);
    rd(SADC_CTRL_ADDR, d);
    check("done kept", 8'hc0, d);
    check("enabled irq", 8'h01, {7'h00, irq_out});
    $display("test mask done");
    wr(SADC_CTRL_ADDR, 8'h10);
    wr(SADC_CTRL_ADDR, 8'hb0);
    repeat (CONV / 2) @(posedge clk_in);
    rd(SADC_CTRL_ADDR, d);
    check("busy control", 8'h90, d);
    convert(8'h6c);
    $display("test restart done");
    wr(SADC_CTRL_ADDR, 8'h20);
    wait_mode_in <= 1'b1;
    repeat (CONV + 24) @(posedge clk_in);
    rd(SADC_CTRL_ADDR, d);
    check("powered down", 8'h00, d);
    check("power pin", 8'h00, {7'h00, analog_power_out});
    wr(SADC_CTRL_ADDR, 8'h40);
    rd(SADC_CTRL_ADDR, d);
    check("done not settable", ctrl_val(1'b0, 1'b0, 1'b0), d);
    $display("test power done");
    wr(SADC_CTRL_ADDR, 8'h10);
    wr(SADC_CTRL_ADDR, 8'hb0);
    repeat (30) @(posedge clk_in);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (CONV + 24) @(posedge clk_in);
    rd(SADC_CTRL_ADDR, d);
    check("aborted by reset", SADC_CTRL_RESET, d);
    rd(SADC_RESULT_ADDR, d);
    check("result after abort", 8'h00, d);
    $display("test reset abort done");
    close_out();
  end
endmodule : sadc_ctrl_tb
